// ---- verilog/wwd_pkg.sv ----
package wwd_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [4:0] OFS_RELOAD_KEY = 5'h00;
  localparam logic [4:0] OFS_CONTROL = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_COUNT_VALUE = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_IRQ_EN_BIT = 1;
  localparam int CTL_CLK_SEL_BIT = 4;
  localparam int CTL_PSEL_LSB = 8;
  localparam int CTL_PSEL_MSB = 11;
  localparam int CTL_CMP_LSB = 16;
  localparam int CTL_CMP_MSB = 21;
  localparam int STS_FLAG_BIT = 0;

  // ****************************************************************
  // Values and timing
  // ****************************************************************
  localparam logic [5:0] COUNT_TOP = 6'h3F;
  localparam logic [5:0] COUNT_ONE = 6'h01;
  localparam logic [5:0] COUNT_ZERO = 6'h00;
  localparam logic [31:0] RELOAD_KEY = 32'h0000_5AA5;
  localparam logic [3:0] PSEL_RESET = 4'h0;
  localparam logic [5:0] CMP_RESET = 6'h00;
  localparam logic MASK_RESET = 1'b1;
  localparam logic [1:0] SYNC_LAST = 2'h2;
  localparam logic [10:0] HCLK_DIV_LAST = 11'h7FF;

  function automatic logic [11:0] prescaleRatio(input logic [3:0] sel);
    logic [11:0] r;
    r = 12'h001;
    unique case (sel)
      4'h0: r = 12'h001;
      4'h1: r = 12'h002;
      4'h2: r = 12'h004;
      4'h3: r = 12'h008;
      4'h4: r = 12'h010;
      4'h5: r = 12'h020;
      4'h6: r = 12'h040;
      4'h7: r = 12'h080;
      4'h8: r = 12'h0C0;
      4'h9: r = 12'h100;
      4'hA: r = 12'h180;
      4'hB: r = 12'h200;
      4'hC: r = 12'h300;
      4'hD: r = 12'h400;
      4'hE: r = 12'h600;
      4'hF: r = 12'h800;
    endcase
    return r;
  endfunction

endpackage

// ---- verilog/wwd_prescaler.sv ----
module wwd_prescaler
  import wwd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tickIn,
  input wire logic clear,
  input wire logic [3:0] prescale_select,
  output logic tickOut
);

  logic [11:0] div_ff;
  logic [11:0] lastVal;

  assign lastVal = prescaleRatio(prescale_select) - 12'h001;
  assign tickOut = tickIn && (div_ff == lastVal) && !clear;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 12'h000;
    end else if (clear || tickOut) begin
      div_ff <= 12'h000;
    end else if (tickIn) begin
      div_ff <= div_ff + 12'h001;
    end
  end

endmodule

// ---- verilog/wwd_window_watchdog.sv ----
// Behaviour
// - 6-bit down counter, compare in control[21:16]
// - Source: system clock/2048 or 10 kHz oscillator
// - Control[11:8] selects prescale ratio 1..2048
// - One decrement per prescaled tick
// - Enable once; starts at 0x3F; no stopping
// - Set match flag when counter equals compare
// - Interrupt when flag set and enabled
// - Reset request when counter reaches zero
// - Key in window reloads counter to 0x3F
// - Key above window raises reset request
// - Control register accepts one write only
// - Reload applies after 3 watchdog clocks
// - Counter value readable at any time
module wwd_window_watchdog
  import wwd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic oscClk,
  output logic irq,
  output logic resetReq
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic ack_ff;
  logic busWr;
  logic busRd;
  logic [31:0] nxt_readdata;
  logic [31:0] readdata_ff;

  assign waitrequest = (read || write) && !ack_ff;
  assign busWr = write && ack_ff;
  assign busRd = read && ack_ff;
  assign readdata = readdata_ff;

  // Every access takes exactly one wait cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read || write) && !ack_ff;
    end
  end

  // ****************************************************************
  // Control, status and mask registers
  // ****************************************************************
  logic enable_ff;
  logic irqEn_ff;
  logic clkSel_ff;
  logic [3:0] psel_ff;
  logic [5:0] cmp_ff;
  logic ctrlLocked_ff;
  logic flag_ff;
  logic mask_ff;
  logic [5:0] count_ff;
  logic tripped_ff;
  logic resetReq_ff;
  logic ctrlWr;
  logic active;

  assign ctrlWr = busWr && (address == OFS_CONTROL) && !ctrlLocked_ff;
  assign active = enable_ff && !tripped_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_ff <= 1'b0;
      irqEn_ff <= 1'b0;
      clkSel_ff <= 1'b0;
      psel_ff <= PSEL_RESET;
      cmp_ff <= CMP_RESET;
      ctrlLocked_ff <= 1'b0;
    end else if (ctrlWr) begin
      enable_ff <= writedata[CTL_ENABLE_BIT];
      irqEn_ff <= writedata[CTL_IRQ_EN_BIT];
      clkSel_ff <= writedata[CTL_CLK_SEL_BIT];
      psel_ff <= writedata[CTL_PSEL_MSB:CTL_PSEL_LSB];
      cmp_ff <= writedata[CTL_CMP_MSB:CTL_CMP_LSB];
      ctrlLocked_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_ff <= MASK_RESET;
    end else if (busWr && (address == OFS_IRQ_MASK)) begin
      mask_ff <= writedata[STS_FLAG_BIT];
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    unique case (address)
      OFS_CONTROL: begin
        nxt_readdata[CTL_ENABLE_BIT] = enable_ff;
        nxt_readdata[CTL_IRQ_EN_BIT] = irqEn_ff;
        nxt_readdata[CTL_CLK_SEL_BIT] = clkSel_ff;
        nxt_readdata[CTL_PSEL_MSB:CTL_PSEL_LSB] = psel_ff;
        nxt_readdata[CTL_CMP_MSB:CTL_CMP_LSB] = cmp_ff;
      end
      OFS_STATUS: nxt_readdata[STS_FLAG_BIT] = flag_ff;
      OFS_COUNT_VALUE: nxt_readdata[5:0] = count_ff;
      OFS_IRQ_MASK: nxt_readdata[STS_FLAG_BIT] = mask_ff;
      default: nxt_readdata = 32'h0000_0000;
    endcase
  end

  // Loaded in the wait cycle so data stands when waitrequest drops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata_ff <= 32'h0000_0000;
    end else if (read && !ack_ff) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // ****************************************************************
  // Watchdog clock sources
  // ****************************************************************
  logic oscSync1_ff;
  logic oscSync2_ff;
  logic oscPrev_ff;
  logic [10:0] hclkDiv_ff;
  logic oscTick;
  logic hclkTick;
  logic srcTick;

  // Oscillator pin is asynchronous; only its rising edge is used
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oscSync1_ff <= 1'b0;
      oscSync2_ff <= 1'b0;
      oscPrev_ff <= 1'b0;
    end else begin
      oscSync1_ff <= oscClk;
      oscSync2_ff <= oscSync1_ff;
      oscPrev_ff <= oscSync2_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hclkDiv_ff <= 11'h000;
    end else begin
      hclkDiv_ff <= hclkDiv_ff + 11'h001;
    end
  end

  assign oscTick = oscSync2_ff && !oscPrev_ff;
  assign hclkTick = (hclkDiv_ff == HCLK_DIV_LAST);
  assign srcTick = clkSel_ff ? oscTick : hclkTick;

  // ****************************************************************
  // Reload handling and trip detection
  // ****************************************************************
  logic reloadPend_ff;
  logic [1:0] syncCnt_ff;
  logic keyWr;
  logic early;
  logic reloadNow;
  logic tick;
  logic zeroTrip;
  logic tripNow;

  assign keyWr = busWr && (address == OFS_RELOAD_KEY)
                 && (writedata == RELOAD_KEY) && active;
  assign early = keyWr && (count_ff > cmp_ff);
  assign reloadNow = reloadPend_ff && srcTick
                     && (syncCnt_ff == SYNC_LAST);
  assign zeroTrip = tick && (count_ff == COUNT_ONE) && !reloadNow;
  assign tripNow = active && (early || zeroTrip);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reloadPend_ff <= 1'b0;
      syncCnt_ff <= 2'h0;
    end else if (reloadNow || !active) begin
      // A key landing on the reload edge is served by that reload
      reloadPend_ff <= 1'b0;
      syncCnt_ff <= 2'h0;
    end else if (keyWr && !early) begin
      reloadPend_ff <= 1'b1;
      syncCnt_ff <= 2'h0;
    end else if (reloadPend_ff && srcTick) begin
      syncCnt_ff <= syncCnt_ff + 2'h1;
    end
  end

  wwd_prescaler u_prescaler (
    .clk(clk),
    .rstn(rstn),
    .tickIn(srcTick),
    .clear(reloadNow || !active),
    .prescale_select(psel_ff),
    .tickOut(tick)
  );

  // ****************************************************************
  // Down counter and reset request
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_ff <= COUNT_TOP;
    end else if (ctrlWr && writedata[CTL_ENABLE_BIT]) begin
      count_ff <= COUNT_TOP;
    end else if (active && reloadNow) begin
      count_ff <= COUNT_TOP;
    end else if (active && tick && count_ff != COUNT_ZERO) begin
      count_ff <= count_ff - COUNT_ONE;
    end
  end

  // After one request the block stays quiet until the chip reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tripped_ff <= 1'b0;
      resetReq_ff <= 1'b0;
    end else begin
      resetReq_ff <= tripNow;
      if (tripNow) begin
        tripped_ff <= 1'b1;
      end
    end
  end

  assign resetReq = resetReq_ff;

  // ****************************************************************
  // Compare match flag and interrupt
  // ****************************************************************
  logic matchNow;
  logic match_ff;
  logic flagSet;
  logic flagClr;

  assign matchNow = active && (count_ff == cmp_ff);
  assign flagSet = matchNow && !match_ff;
  assign flagClr = busWr && (address == OFS_STATUS)
                   && writedata[STS_FLAG_BIT];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= matchNow;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_ff <= 1'b0;
    end else if (flagSet) begin
      flag_ff <= 1'b1;
    end else if (flagClr) begin
      flag_ff <= 1'b0;
    end
  end

  assign irq = flag_ff && irqEn_ff && mask_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_reset_single_pulse: assert property (
    resetReq |=> !resetReq [*3]
  ) else $error("reset request not a single pulse");

  a_early_key_trip: assert property (
    (keyWr && count_ff > cmp_ff) |=> resetReq && tripped_ff
  ) else $error("early key did not raise reset");

  a_zero_trip: assert property (
    (active && tick && count_ff == COUNT_ONE && !reloadNow)
      |=> count_ff == COUNT_ZERO && resetReq
  ) else $error("counter reached zero without reset");

  a_reload_top: assert property (
    (active && reloadNow) |=> count_ff == COUNT_TOP && !reloadPend_ff
  ) else $error("reload did not restore top value");

  a_reload_sync: assert property (
    (keyWr && !early) |=> !reloadNow until_with (syncCnt_ff == SYNC_LAST)
  ) else $error("reload applied before sync");

  a_ctrl_locked: assert property (
    ctrlLocked_ff |=> $stable(psel_ff) && $stable(cmp_ff)
      && $stable(enable_ff)
  ) else $error("control changed after first write");

  a_enable_start: assert property (
    (ctrlWr && writedata[CTL_ENABLE_BIT]) |=> enable_ff
      && count_ff == COUNT_TOP
  ) else $error("enable did not start at top");

  a_flag_sticky: assert property (
    (flag_ff && !flagClr) |=> flag_ff
  ) else $error("match flag lost without clear");

  a_match_irq: assert property (
    (flagSet && irqEn_ff && mask_ff) |=> irq
  ) else $error("match did not raise interrupt");

  a_one_decrement: assert property (
    (active && !tick && !reloadNow && !ctrlWr) |=> $stable(count_ff)
  ) else $error("counter moved without tick");

  a_bus_wait: assert property (
    ((read || write) && !ack_ff) |-> waitrequest ##1 !waitrequest
  ) else $error("bus wait not exactly one cycle");

  a_match_flag_set: assert property (
    (active && count_ff == cmp_ff && !match_ff) |=> flag_ff
  ) else $error("match did not set flag");

  a_trip_quiet: assert property (
    (tripped_ff && !resetReq) |=> !resetReq
  ) else $error("second reset request after trip");

  a_count_read: assert property (
    (read && !ack_ff && address == OFS_COUNT_VALUE)
      |=> readdata[5:0] == $past(count_ff)
  ) else $error("count value read back wrong");

  a_enable_stays: assert property (
    enable_ff |=> enable_ff
  ) else $error("counting stopped without reset");

  a_zero_hold: assert property (
    (enable_ff && count_ff == COUNT_ZERO) |=> count_ff == COUNT_ZERO
  ) else $error("counter left zero before reset");

endmodule

// ---- test/tb_window_watchdog_timer.sv ----
module tb_window_watchdog_timer
  import wwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  `define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin \
    miscompares++; $display("Error %s expected %h seen %h", nm, ex, gt); \
    end end

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic oscClk = 1'b0;
  logic irq;
  logic resetReq;
  int miscompares = 0;
  int testsRun = 0;
  int resetPulses = 0;
  logic [31:0] rv;
  logic [31:0] rv2;
  int n;

  wwd_window_watchdog DUT (.clk(clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .oscClk(oscClk),
    .irq(irq), .resetReq(resetReq));

  initial begin
    forever #5 clk = ~clk;
  end

  // Oscillator stand-in at clk/8, well inside the sync limit
  always begin
    repeat (4) @(posedge clk);
    oscClk <= ~oscClk;
  end

  // Counts high cycles, so one pulse of one cycle reads as 1
  always @(posedge clk) begin
    if (resetReq === 1'b1) resetPulses++;
  end

  // ****************************************************************
  // Bus access
  // ****************************************************************
  task automatic access(input logic wr, input logic [4:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    // Waitrequest is sampled at the rising edge, before it updates
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      miscompares++;
      $display("Error bus access timed out at address %h", a);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    access(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    access(1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic doReset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    resetPulses = 0;
  endtask

  task automatic waitFlag();
    n = 0;
    do rd(OFS_STATUS, rv); while (rv[0] !== 1'b1 && ++n < 300);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    doReset();
    rd(OFS_COUNT_VALUE, rv);
    `CHK("count reset", COUNT_TOP, rv[5:0])
    rd(OFS_CONTROL, rv);
    `CHK("control reset", 32'h0000_0000, rv)
    rd(OFS_IRQ_MASK, rv);
    `CHK("mask reset", 1'b1, rv[0])
    rd(5'h14, rv);
    `CHK("unmapped", 32'h0000_0000, rv)
    // Ratio 2 on the fast oscillator: one step per 16 clocks
    wr(OFS_CONTROL, 32'h003F_0111);
    waitFlag();
    `CHK("match at top", 1'b1, rv[0])
    `CHK("irq disabled", 1'b0, irq)
    rd(OFS_COUNT_VALUE, rv);
    repeat (160) @(posedge clk);
    rd(OFS_COUNT_VALUE, rv2);
    n = rv[5:0] - rv2[5:0];
    `CHK("prescale 2", 1'b1, n >= 9 && n <= 11)
    $display("Test prescale done");

    doReset();
    wr(OFS_CONTROL, 32'h003C_0013);
    waitFlag();
    rd(OFS_COUNT_VALUE, rv2);
    `CHK("in window", 1'b1, rv2[5:0] <= 6'h3C)
    `CHK("irq on", 1'b1, irq)
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    // Mask lands on this edge; look once it has settled
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0000);
    rd(OFS_STATUS, rv);
    `CHK("flag sticky", 1'b1, rv[0])
    wr(OFS_STATUS, 32'h0000_0001);
    rd(OFS_STATUS, rv);
    `CHK("flag cleared", 1'b0, rv[0])
    `CHK("irq off", 1'b0, irq)
    wr(OFS_RELOAD_KEY, RELOAD_KEY);
    // Reload lands within 24 clocks; read before a second step
    repeat (30) @(posedge clk);
    rd(OFS_COUNT_VALUE, rv);
    `CHK("reloaded", 1'b1, rv[5:0] > 6'h3C)
    `CHK("no reset", 0, resetPulses)
    waitFlag();
    `CHK("match again", 1'b1, rv[0])
    wr(OFS_CONTROL, 32'h0020_0000);
    rd(OFS_CONTROL, rv);
    `CHK("control locked", 32'h003C_0013, rv)
    n = 0;
    while (resetPulses == 0 && ++n < 1000) @(posedge clk);
    rd(OFS_COUNT_VALUE, rv);
    `CHK("count zero", COUNT_ZERO, rv[5:0])
    repeat (50) @(posedge clk);
    `CHK("timeout pulse", 1, resetPulses)
    $display("Test window done");

    doReset();
    rd(OFS_COUNT_VALUE, rv);
    `CHK("back disabled", COUNT_TOP, rv[5:0])
    wr(OFS_CONTROL, 32'h0030_0001);
    repeat (2100) @(posedge clk);
    rd(OFS_COUNT_VALUE, rv);
    `CHK("clk div", 1'b1, rv[5:0] == 6'h3E || rv[5:0] == 6'h3D)
    `CHK("no early", 0, resetPulses)
    wr(OFS_RELOAD_KEY, RELOAD_KEY);
    repeat (20) @(posedge clk);
    `CHK("early key", 1, resetPulses)
    $display("Test early key done");
    end_of_test();
  end
endmodule
